// ### src/ldsc_pkg.sv
// package: shared types and constants for the led shutdown control block
`default_nettype none
package ldsc_pkg;
   // =========================================================
   // sizes and reset values
   localparam int LDSC_CHANNELS = 18;
   localparam int LDSC_ADDR_W = 8;
   localparam int LDSC_DATA_W = 8;
   localparam int LDSC_NUM_REGS = 256;
   localparam logic [7:0] LDSC_CTRL_OFFSET = 8'h00;
   localparam int LDSC_RUN_BIT_POS = 0;
   localparam logic [7:0] LDSC_REG_RESET = 8'h00;
   localparam logic LDSC_RUN_RESET = 1'b0;
   // idle level of the active-low shutdown pin, also the edge detector reset value
   localparam logic LDSC_PIN_IDLE = 1'b1;
   localparam logic [17:0] LDSC_OUTS_OFF = 18'h00000;

   // =========================================================
   // shutdown state of the device
   typedef enum logic [1:0] {
      LDSC_ST_HW_SHDN,
      LDSC_ST_SW_SHDN,
      LDSC_ST_RUN
   } ldsc_mode_e;

   // register access request from the serial front end
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } ldsc_req_s;
endpackage
`default_nettype wire

// ### src/ldsc_edge.sv
// module: rising edge detector for the active-low shutdown pin
`default_nettype none
module ldsc_edge
   import ldsc_pkg::*;
(
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // level in
   input wire logic i_level,
   // outputs
   output logic o_level,
   output logic o_rise
);
   // =========================================================
   // previous sample, reset to the idle high level so release makes no false edge
   logic prev_ff;
   // previous sample register
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         prev_ff <= LDSC_PIN_IDLE;
      end else begin
         prev_ff <= i_level;
      end
   end
   // edge is a plain compare of current and previous level
   assign o_level = prev_ff;
   assign o_rise = i_level & ~prev_ff;
endmodule
`default_nettype wire

// ### src/ldsc_top.sv
// module: shutdown control with register file and output gating
`default_nettype none
// How it works
// RULE_01 - run bit zero enters software shutdown
// RULE_02 - software shutdown: outputs off, registers accessible
// RULE_03 - low shutdown pin enters hardware shutdown
// RULE_04 - hardware shutdown keeps all outputs off
// RULE_05 - pin high leaves shutdown, resumes operation
// RULE_06 - pin rising edge resets serial interface
// RULE_07 - serial interface reset keeps register contents
// RULE_08 - registers accessible during hardware shutdown
// RULE_09 - host rewrites registers after supply sag
// RULE_10 - run bit resets to zero
// RULE_11 - registers preserved through both shutdowns
// RULE_12 - outputs on only with pin high, run set
module ldsc_top
   import ldsc_pkg::*;
(
   // clock and reset
   input wire logic I_CLK,
   input wire logic I_RST,
   // shutdown pin, active low
   input wire logic I_SHUTDOWN_PIN_N,
   // register request from the serial front end
   input wire ldsc_req_s I_REQ,
   // channel pattern wanted by the output datapath
   input wire logic [17:0] I_CH_ON,
   // read data and status
   output logic [7:0] O_RDATA,
   output logic O_RVALID,
   output logic O_SERIAL_RST,
   output logic [1:0] O_MODE,
   // current source enables
   output logic [17:0] O_CS_EN
);
   // =========================================================
   // edge detection on the shutdown pin
   // pin level as taken this cycle, high means not held off
   logic pin_high;
   // one-cycle strobe on a low-to-high pin change
   logic pin_rise;
   // pin level one cycle back, used by the checks only
   logic pin_level_d;
   // the edge detector also feeds the assertions below
   ldsc_edge u_edge (
      .i_clk(I_CLK),
      .i_rst(I_RST),
      .i_level(I_SHUTDOWN_PIN_N),
      .o_level(pin_level_d),
      .o_rise(pin_rise)
   );
   // the pin is taken as synchronous, so no extra stage
   assign pin_high = I_SHUTDOWN_PIN_N;

   // =========================================================
   // register file in flip-flops
   // one byte per address, all reset to zero
   logic [7:0] regs_ff [LDSC_NUM_REGS];
   // run bit picked out of the control register
   logic run_enable_bit;
   assign run_enable_bit = regs_ff[LDSC_CTRL_OFFSET][LDSC_RUN_BIT_POS];

   // one flop per register; no shutdown or pin term touches them
   genvar gi;
   generate
      for (gi = 0; gi < LDSC_NUM_REGS; gi++) begin : g_reg
         // RULE_10 run bit clears
         always_ff @(posedge I_CLK or posedge I_RST) begin
            if (I_RST) begin
               regs_ff[gi] <= LDSC_REG_RESET;
            // RULE_08 writes in shutdown
            end else if (I_REQ.wr && I_REQ.addr == 8'(gi)) begin
               // write lands one cycle after the strobe
               regs_ff[gi] <= I_REQ.wdata;
            end
         end
      end
   endgenerate
   // RULE_11 contents kept in every mode
   // RULE_07 no serial reset path
   // RULE_02 access in software shutdown

   // =========================================================
   // read port, works in every mode
   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         // nothing to answer until the first read
         O_RDATA <= 8'h00;
         O_RVALID <= 1'b0;
      end else begin
         // answer flag follows the read strobe by one cycle
         O_RVALID <= I_REQ.rd;
         // data holds between reads
         if (I_REQ.rd) begin
            O_RDATA <= regs_ff[I_REQ.addr];
         end
      end
   end

   // =========================================================
   // serial interface reset pulse
   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         // no pulse while held in reset
         O_SERIAL_RST <= 1'b0;
      end else begin
         // RULE_06 pulse on rise
         O_SERIAL_RST <= pin_rise;
      end
   end

   // =========================================================
   // mode decision, pin has priority
   // mode wanted for the next cycle
   ldsc_mode_e nxt_mode;
   // mode as shown on the output
   ldsc_mode_e mode_ff;
   always_comb begin
      // RULE_03 pin low
      if (!pin_high) begin
         nxt_mode = LDSC_ST_HW_SHDN;
      // RULE_01 run bit zero
      end else if (!run_enable_bit) begin
         nxt_mode = LDSC_ST_SW_SHDN;
      // RULE_05 pin high resumes
      end else begin
         nxt_mode = LDSC_ST_RUN;
      end
   end
   // mode register
   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         // held in hardware shutdown while reset is applied
         mode_ff <= LDSC_ST_HW_SHDN;
      end else begin
         mode_ff <= nxt_mode;
      end
   end
   assign O_MODE = mode_ff;

   // =========================================================
   // current source gating
   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         // all sources off while reset is applied
         O_CS_EN <= LDSC_OUTS_OFF;
      end else begin
         // same decision as the mode, so mode and enables move together
         case (nxt_mode)
            // RULE_12 both conditions needed
            LDSC_ST_RUN: O_CS_EN <= I_CH_ON;
            // RULE_04 outputs off
            default: O_CS_EN <= LDSC_OUTS_OFF;
         endcase
      end
   end

   // =========================================================
   // assertions
   // all checks sleep while reset is applied
   a_pin_low_off: assert property (@(posedge I_CLK) disable iff (I_RST) // RULE_04
      !I_SHUTDOWN_PIN_N |=> O_CS_EN == LDSC_OUTS_OFF)
      else $error("outputs on while pin low");
   a_pin_low_mode: assert property (@(posedge I_CLK) disable iff (I_RST) // RULE_03
      !I_SHUTDOWN_PIN_N |=> O_MODE == LDSC_ST_HW_SHDN)
      else $error("pin low did not give hardware shutdown");
   a_run_zero_off: assert property (@(posedge I_CLK) disable iff (I_RST) // RULE_01
      (I_SHUTDOWN_PIN_N && !run_enable_bit) |=> O_MODE == LDSC_ST_SW_SHDN)
      else $error("run bit zero did not give software shutdown");
   a_sw_outputs_off: assert property (@(posedge I_CLK) disable iff (I_RST) // RULE_02
      !run_enable_bit |=> O_CS_EN == LDSC_OUTS_OFF)
      else $error("outputs on in software shutdown");
   a_resume_run: assert property (@(posedge I_CLK) disable iff (I_RST) // RULE_05
      (I_SHUTDOWN_PIN_N && run_enable_bit) |=> O_CS_EN == $past(I_CH_ON))
      else $error("outputs not following pattern in run");
   a_both_needed: assert property (@(posedge I_CLK) disable iff (I_RST) // RULE_12
      O_CS_EN != LDSC_OUTS_OFF |-> $past(I_SHUTDOWN_PIN_N) && $past(run_enable_bit))
      else $error("outputs on without both enables");
   a_rise_resets: assert property (@(posedge I_CLK) disable iff (I_RST) // RULE_06
      (I_SHUTDOWN_PIN_N && !pin_level_d) |=> O_SERIAL_RST ##1 !O_SERIAL_RST)
      else $error("serial reset pulse wrong");
   a_regs_kept: assert property (@(posedge I_CLK) disable iff (I_RST) // RULE_11
      (!I_REQ.wr) |=> regs_ff[LDSC_CTRL_OFFSET] == $past(regs_ff[LDSC_CTRL_OFFSET]))
      else $error("control register changed without write");
   a_hw_write: assert property (@(posedge I_CLK) disable iff (I_RST) // RULE_08
      (!I_SHUTDOWN_PIN_N && I_REQ.wr)
      |=> regs_ff[$past(I_REQ.addr)] == $past(I_REQ.wdata))
      else $error("write lost in hardware shutdown");
   a_serial_keep: assert property (@(posedge I_CLK) disable iff (I_RST) // RULE_07
      (O_SERIAL_RST && !$past(I_REQ.wr))
      |-> regs_ff[LDSC_CTRL_OFFSET] == $past(regs_ff[LDSC_CTRL_OFFSET]))
      else $error("serial reset changed registers");
   a_read_back: assert property (@(posedge I_CLK) disable iff (I_RST) // RULE_02
      I_REQ.rd |=> O_RVALID)
      else $error("read not answered");
   a_quiet_serial: assert property (@(posedge I_CLK) disable iff (I_RST) // RULE_06
      !pin_rise |=> !O_SERIAL_RST)
      else $error("serial reset without pin rise");
   a_pulse_once: assert property (@(posedge I_CLK) disable iff (I_RST) // RULE_06
      O_SERIAL_RST |=> !O_SERIAL_RST)
      else $error("serial reset longer than one cycle");
   a_read_pulse: assert property (@(posedge I_CLK) disable iff (I_RST) // RULE_08
      !I_REQ.rd |=> !O_RVALID)
      else $error("read answer without a read");
   a_hw_mode_off: assert property (@(posedge I_CLK) disable iff (I_RST) // RULE_04
      O_MODE == LDSC_ST_HW_SHDN |-> O_CS_EN == LDSC_OUTS_OFF)
      else $error("outputs on in hardware shutdown mode");
   a_sw_mode_off: assert property (@(posedge I_CLK) disable iff (I_RST) // RULE_02
      O_MODE == LDSC_ST_SW_SHDN |-> O_CS_EN == LDSC_OUTS_OFF)
      else $error("outputs on in software shutdown mode");
   a_pin_high_run: assert property (@(posedge I_CLK) disable iff (I_RST) // RULE_05
      (I_SHUTDOWN_PIN_N && run_enable_bit) |=> O_MODE == LDSC_ST_RUN)
      else $error("pin high with run bit did not resume");
   // covers
   c_run: cover property (@(posedge I_CLK) disable iff (I_RST) O_MODE == LDSC_ST_RUN);
   c_sw: cover property (@(posedge I_CLK) disable iff (I_RST) O_MODE == LDSC_ST_SW_SHDN);
   c_hw: cover property (@(posedge I_CLK) disable iff (I_RST) O_MODE == LDSC_ST_HW_SHDN);
   c_rise: cover property (@(posedge I_CLK) disable iff (I_RST) O_SERIAL_RST);
   c_hw_wr: cover property (@(posedge I_CLK) disable iff (I_RST)
      !I_SHUTDOWN_PIN_N && I_REQ.wr);
endmodule
`default_nettype wire

// ### dv/ldsc_host.sv
// host model: drives register requests, the shutdown pin and the channel pattern
`default_nettype none
module ldsc_host
   import ldsc_pkg::*;
(
   // clock
   input wire logic i_clk,
   // toward the block
   output ldsc_req_s o_req,
   output logic o_pin_n,
   output logic [17:0] o_ch_on
);
   timeunit 1ns;
   timeprecision 1ps;
   // idle values at time zero, pin high so the part is not held off
   initial begin
      o_req = '{wr: 1'b0, rd: 1'b0, addr: 8'h00, wdata: 8'h00};
      o_pin_n = 1'b1;
      o_ch_on = 18'h00000;
   end
   // one-cycle request, then fields scrambled so stale values are not trusted
   task automatic access(input logic wr, input logic rd, input logic [7:0] a,
                         input logic [7:0] d);
      @(posedge i_clk);
      o_req <= '{wr: wr, rd: rd, addr: a, wdata: d};
      @(posedge i_clk);
      o_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
   endtask
   // pin level change on a clock edge
   // no sag modelled
   // no supply sag is modelled, so no rewrite is owed before raising the pin
   task automatic set_pin(input logic v);
      @(posedge i_clk);
      o_pin_n <= v;
   endtask
   // pattern asked for by the datapath
   // host enables run
   // outputs are only expected after the run bit has been written to one
   task automatic set_ch(input logic [17:0] p);
      @(posedge i_clk);
      o_ch_on <= p;
   endtask
endmodule
`default_nettype wire

// ### dv/tb_ldsc_top.sv
// testbench for the led shutdown control block
`default_nettype none
module tb_ldsc_top
   import ldsc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0; // 40 MHz clock
   logic rst = 1'b1; // async reset
   ldsc_req_s req;
   logic pin_n;
   logic [17:0] ch_on;
   logic [7:0] rdata;
   logic rvalid;
   logic srst;
   logic [1:0] mode;
   logic [17:0] cs_en;
   int err_total = 0;
   int compares = 0;
   localparam logic [17:0] PAT = 18'h2A5A5; // arbitrary channel pattern
   always #12.5 clk = ~clk;
   ldsc_host host (.i_clk(clk), .o_req(req), .o_pin_n(pin_n), .o_ch_on(ch_on));
   ldsc_top DUT (.I_CLK(clk), .I_RST(rst), .I_SHUTDOWN_PIN_N(pin_n), .I_REQ(req),
      .I_CH_ON(ch_on), .O_RDATA(rdata), .O_RVALID(rvalid), .O_SERIAL_RST(srst),
      .O_MODE(mode), .O_CS_EN(cs_en));
   // compare and count
   task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
      compares++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   // verdict and end of run
   task automatic stop_test();
      if (err_total == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // read one register and compare the answer
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      host.access(1'b0, 1'b1, a, 8'h00);
      @(negedge clk);
      chk(18'(rvalid), 18'h00001);
      chk(18'(rdata), 18'(exp));
   endtask
   // let mode and enables settle, then compare
   task automatic mode_chk(input logic [1:0] m, input logic [17:0] cs);
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk(18'(mode), 18'(m));
      chk(cs_en, cs);
   endtask
   // state straight after reset
   task automatic t_reset();
      host.set_ch(PAT);
      mode_chk(LDSC_ST_SW_SHDN, LDSC_OUTS_OFF);
      rd_chk(LDSC_CTRL_OFFSET, LDSC_REG_RESET);
   endtask
   // run bit set, outputs follow the pattern
   task automatic t_run();
      host.access(1'b1, 1'b0, LDSC_CTRL_OFFSET, 8'h01);
      mode_chk(LDSC_ST_RUN, PAT);
   endtask
   // pin low: outputs off, registers still reachable and kept
   task automatic t_hw();
      host.set_pin(1'b0);
      mode_chk(LDSC_ST_HW_SHDN, LDSC_OUTS_OFF);
      host.access(1'b1, 1'b0, 8'h05, 8'hA5);
      rd_chk(8'h05, 8'hA5);
      rd_chk(LDSC_CTRL_OFFSET, 8'h01);
   endtask
   // pin rising: exactly one serial reset pulse, contents kept, run resumes
   task automatic t_rise();
      int n;
      n = 0;
      host.set_pin(1'b1);
      repeat (6) begin
         @(negedge clk);
         if (srst === 1'b1) n++;
      end
      chk(n[17:0], 18'h00001);
      mode_chk(LDSC_ST_RUN, PAT);
      rd_chk(8'h05, 8'hA5);
   endtask
   // run bit cleared with other bits set: software shutdown
   task automatic t_sw();
      host.access(1'b1, 1'b0, LDSC_CTRL_OFFSET, 8'hFE);
      mode_chk(LDSC_ST_SW_SHDN, LDSC_OUTS_OFF);
      rd_chk(8'h05, 8'hA5);
      rd_chk(LDSC_CTRL_OFFSET, 8'hFE);
   endtask
   // reset in mid-run: run bit back to zero, outputs off, mode back to software shutdown
   task automatic t_rerun();
      host.access(1'b1, 1'b0, LDSC_CTRL_OFFSET, 8'h01);
      mode_chk(LDSC_ST_RUN, PAT);
      @(posedge clk);
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      mode_chk(LDSC_ST_SW_SHDN, LDSC_OUTS_OFF);
      rd_chk(LDSC_CTRL_OFFSET, LDSC_REG_RESET);
   endtask
   // main sequence
   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_run();
      t_hw();
      t_rise();
      t_sw();
      t_rerun();
      stop_test();
   end
   // watchdog well past the expected run length
   initial begin
      repeat (2000) @(posedge clk);
      err_total++;
      stop_test();
   end
endmodule
`default_nettype wire
